// ===== rtl/dac_ctrl_params.svh
// Purpose: Constants for the toggle, monitor and thermal control block
// Assumes: Word decode arrives already parallel from the serial front end
// Notes: Bit positions refer to the 14-bit special control register
//
// How it works
// [RULE1] Monitor mode turns the last channel pin into the shared monitor.
// [RULE2] Host enables the monitor before sending any routing selection.
// [RULE3] Monitor selection 63 floats the monitor pin, routes nothing.
// [RULE4] Select bits 00, address 001100 write the control register.
// [RULE5] Five control bits each enable toggling for eight channels.
// [RULE6] Every one of the 40 channels has an A and a B register.
// [RULE7] B writes land only while that channel's group toggles.
// [RULE8] Host order: enable groups, load A, load B, then strobe.
// [RULE9] First strobe after enabling drives outputs from A.
// [RULE10] Later strobes alternate A and B on toggling channels.
// [RULE11] After toggle disable, next strobe loads A contents.
// [RULE12] Thermal protection only works while its enable bit is set.
// [RULE13] Overheat with protection on powers all amplifiers down.
// [RULE14] Amplifiers stay off until soft power-up when cool, or disable.
// [RULE15] Power-on reset loads defaults, outputs sit at zero volts.
// [RULE16] Hardware reset acts like power-on reset; host applies it late.
// [RULE17] Toggling need not work during burst auto-increment writes.
// [RULE18] Selecting an existing channel routes exactly that one.
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// Register decode
// ----------------------------------------------------------------
`define REGSEL_CTRL 2'h0
`define REGSEL_DATA 2'h3
`define CTRL_ADDR 6'h0c
`define MONSEL_ADDR 6'h0d
`define MON_TRISTATE 6'h3f

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define CTRL_RESET 14'h0000
`define TOG_LO_BIT 2
`define TOG_HI_BIT 6
`define TPE_BIT 8
`define MONEN_BIT 10

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define NUM_CH 40
`define CODE_W 14
`define NUM_GRP 5

`endif

// ===== rtl/dac_ctrl_pkg.sv
// Purpose: Shared types for the control block
// Assumes: Params header supplies the sizes
// Notes: None
`include "dac_ctrl_params.svh"
package dac_ctrl_pkg;
    typedef logic [`CODE_W-1:0] code_t;
    typedef logic [5:0] chan_t;
    typedef logic [1:0] regsel_t;
    typedef logic [`NUM_GRP-1:0] grp_t;
endpackage

// ===== rtl/mem_if.sv
// Purpose: Carrier between the controller and a register memory
// Assumes: One write port, one registered read port
// Notes: None
interface mem_if #(parameter int W = 14, parameter int AW = 6);
    logic we;
    logic [AW-1:0] waddr;
    logic [W-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0] rdata;
    modport ctrl(output we, output waddr, output wdata, output raddr,
                 input rdata);
    modport mem(input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface

// ===== rtl/dac_reg_mem.sv
// Purpose: One bank of per-channel data registers
// Assumes: Addresses beyond depth are never written
// Notes: Cleared on reset so outputs start at code zero
module dac_reg_mem #(
    parameter int W = 14,
    parameter int D = 40
) (
    input wire logic mclk, // System clock
    input wire logic nrst, // Async reset, active low
    mem_if.mem bus         // Write and read port
);
    logic [W-1:0] store_q [D];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < D; i++) begin
                store_q[i] <= '0; // RULE15
            end
        end else if (bus.we) begin
            store_q[bus.waddr] <= bus.wdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bus.rdata <= '0;
        end else begin
            bus.rdata <= store_q[bus.raddr];
        end
    end
endmodule

// ===== rtl/dac_toggle_monitor_ctrl.sv
// Purpose: Toggle mode, channel monitor routing and thermal shutdown
// Assumes: Write strobes come from same-clock interface logic
// Notes: Strobe and overheat pins are synchronised before use
`include "dac_ctrl_params.svh"
module dac_toggle_monitor_ctrl (
    input wire logic mclk,                       // 250 MHz clock
    input wire logic nrst,                       // Async reset, low
    input wire logic wrValid,                    // Decoded write pulse
    input wire dac_ctrl_pkg::regsel_t wrRegSel,  // Register select bits
    input wire dac_ctrl_pkg::chan_t wrAddr,      // Channel address field
    input wire dac_ctrl_pkg::code_t wrData,      // Data word
    input wire logic wrSelB,                     // Data write targets B
    input wire logic burstMode,                  // Auto-increment active
    input wire logic softPowerUp,                // Soft power-up pulse
    input wire logic loadStrobeN,                // Load strobe pin, low
    input wire logic overTemp,                   // Overheat pin, high
    output logic [`NUM_CH*`CODE_W-1:0] dacCode_q, // Channel codes
    output logic ampOn_q,                        // Amplifiers powered
    output logic lastChIsMonitor_q,              // Last pin is monitor
    output dac_ctrl_pkg::chan_t monitorSel_q,    // Routed channel
    output logic monitorOe_q,                    // Monitor pin driven
    output dac_ctrl_pkg::code_t ctrlReg_q,       // Control readback
    output logic outputsValid_q                  // A or B data write seen
);
    import dac_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic ld1_q, ld2_q, ld3_q;
    logic ot1_q, ot2_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {ld1_q, ld2_q, ld3_q} <= 3'h7;
            {ot1_q, ot2_q} <= 2'h0;
        end else begin
            {ld1_q, ld2_q, ld3_q} <= {loadStrobeN, ld1_q, ld2_q};
            {ot1_q, ot2_q} <= {overTemp, ot1_q};
        end
    end

    wire strobeFall = ld3_q & ~ld2_q;

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    wire grp_t togEn = ctrlReg_q[`TOG_HI_BIT:`TOG_LO_BIT]; // RULE5
    wire tpe = ctrlReg_q[`TPE_BIT];
    wire ctrlSel = wrValid && wrRegSel == `REGSEL_CTRL;
    wire ctrlWrite = ctrlSel && wrAddr == `CTRL_ADDR; // RULE4
    wire dataWrite = wrValid && wrRegSel == `REGSEL_DATA &&
                     wrAddr < 6'(`NUM_CH);
    // Burst writes never reach B so toggling is unsupported there
    wire bWrite = dataWrite && wrSelB && togEn[wrAddr[5:3]] &&
                  !burstMode; // RULE7 RULE17
    wire aWrite = dataWrite && !wrSelB;
    wire code_t ctrl_d = ctrlWrite ? wrData : ctrlReg_q;
    wire monEn_d = ctrl_d[`MONEN_BIT];
    // Selections sent before the monitor is enabled are dropped
    wire monWrite = ctrlSel && wrAddr == `MONSEL_ADDR &&
                    ctrlReg_q[`MONEN_BIT]; // RULE2
    wire chan_t monSel_d = monWrite ? wrData[5:0] : monitorSel_q; // RULE18

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrlReg_q <= `CTRL_RESET; // RULE15 RULE16
            monitorSel_q <= `MON_TRISTATE;
            monitorOe_q <= 1'b0;
            lastChIsMonitor_q <= 1'b0;
            outputsValid_q <= 1'b0;
        end else begin
            ctrlReg_q <= ctrl_d;
            monitorSel_q <= monSel_d;
            monitorOe_q <= monEn_d && monSel_d != `MON_TRISTATE; // RULE3
            lastChIsMonitor_q <= monEn_d; // RULE1
            outputsValid_q <= outputsValid_q | dataWrite;
        end
    end

    // ----------------------------------------------------------------
    // A and B banks
    // ----------------------------------------------------------------
    mem_if #(.W(`CODE_W), .AW(6)) memA ();
    mem_if #(.W(`CODE_W), .AW(6)) memB ();

    dac_reg_mem #(.W(`CODE_W), .D(`NUM_CH)) bankA (
        .mclk(mclk),
        .nrst(nrst),
        .bus(memA)
    ); // RULE6
    dac_reg_mem #(.W(`CODE_W), .D(`NUM_CH)) bankB (
        .mclk(mclk),
        .nrst(nrst),
        .bus(memB)
    );

    logic [5:0] idx_q, wrIdx_q;
    logic running_q, wrGo_q, pend_q;
    grp_t phase_q, useB_q;

    assign memA.we = aWrite;
    assign memA.waddr = wrAddr;
    assign memA.wdata = wrData;
    assign memA.raddr = idx_q;
    assign memB.we = bWrite;
    assign memB.waddr = wrAddr;
    assign memB.wdata = wrData;
    assign memB.raddr = idx_q;

    // ----------------------------------------------------------------
    // Load strobe scan
    // ----------------------------------------------------------------
    // Outputs update over 40 cycles; a strobe during a scan is queued
    wire startScan = (strobeFall | pend_q) & ~running_q;
    wire lastIdx = idx_q == 6'(`NUM_CH - 1);
    // Phase set means the next strobe shows B
    wire grp_t phase_d = startScan ? (togEn & ~phase_q)
                                   : (phase_q & togEn); // RULE10 RULE9
    wire code_t outCode = useB_q[wrIdx_q[5:3]] ? memB.rdata
                                               : memA.rdata; // RULE11

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= '0;
            useB_q <= '0;
            pend_q <= 1'b0;
            running_q <= 1'b0;
            idx_q <= '0;
        end else begin
            phase_q <= phase_d;
            pend_q <= (strobeFall & running_q) | (pend_q & ~startScan);
            if (startScan) begin
                useB_q <= togEn & phase_q;
                running_q <= 1'b1;
                idx_q <= '0;
            end else if (running_q) begin
                running_q <= !lastIdx;
                idx_q <= lastIdx ? 6'h00 : idx_q + 6'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wrGo_q <= 1'b0;
            wrIdx_q <= '0;
        end else begin
            wrGo_q <= running_q;
            wrIdx_q <= idx_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dacCode_q <= '0; // RULE15
        end else if (wrGo_q) begin
            dacCode_q[wrIdx_q*`CODE_W +: `CODE_W] <= outCode;
        end
    end

    // ----------------------------------------------------------------
    // Thermal shutdown
    // ----------------------------------------------------------------
    // Overheat wins over a simultaneous soft power-up
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ampOn_q <= 1'b1;
        end else begin
            ampOn_q <= !tpe || (!ot2_q && // RULE12 RULE13
                       (ampOn_q || softPowerUp)); // RULE14
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_hot;
        tpe && ot2_q;
    endsequence
    sequence s_off_hold;
        !ampOn_q && tpe && !softPowerUp;
    endsequence

    chk_ctrl_decode: assert property (
        ctrlWrite |=> ctrlReg_q == $past(wrData)) // RULE4
        else $error("control write not stored");
    chk_ctrl_hold: assert property (!ctrlWrite |=> $stable(ctrlReg_q)) // RULE4
        else $error("control register changed without a write");
    chk_mon_float: assert property (
        monitorOe_q |-> monitorSel_q != `MON_TRISTATE) // RULE3
        else $error("monitor driven on address 63");
    chk_mon_pin: assert property (
        $rose(ctrlReg_q[`MONEN_BIT]) |-> lastChIsMonitor_q) // RULE1
        else $error("last pin not switched to monitor");
    chk_mon_route: assert property (
        monWrite |=> monitorSel_q == $past(wrData[5:0])) // RULE18
        else $error("monitor selection not taken");
    chk_b_gate: assert property (
        memB.we |-> togEn[wrAddr[5:3]] && !burstMode) // RULE7
        else $error("B write while toggle off");
    chk_first_a: assert property ($rose(togEn[0]) |-> !phase_q[0]) // RULE9
        else $error("toggle starts on B");
    chk_toggle_alt: assert property (
        startScan && togEn[0] |=> phase_q[0] != $past(phase_q[0])) // RULE10
        else $error("toggle phase did not flip");
    chk_disabled_a: assert property (
        startScan && !togEn[1] |=> !useB_q[1]) // RULE11
        else $error("disabled group shows B");
    chk_scan_run: assert property (startScan |=> running_q[*8]) // RULE6
        else $error("scan ended early");
    chk_thermal_off: assert property (s_hot |=> !ampOn_q) // RULE13
        else $error("amplifiers stayed on when hot");
    chk_thermal_gate: assert property (!tpe |=> ampOn_q) // RULE12
        else $error("shutdown without protection");
    chk_stay_off: assert property (s_off_hold |=> !ampOn_q) // RULE14
        else $error("amplifiers woke unasked");
    // Scan must step one channel per cycle and stop after the last
    chk_scan_idx: assert property (
        running_q && !lastIdx |=> idx_q == $past(idx_q) + 6'h01) // RULE6
        else $error("scan skipped a channel");
    chk_scan_end: assert property (
        running_q && lastIdx |=> !running_q) // RULE10
        else $error("scan did not stop after last channel");
    chk_valid_hold: assert property (
        outputsValid_q |=> outputsValid_q) // RULE15
        else $error("valid write flag dropped");
endmodule

// ===== testbench/dac_host_model.sv
// Purpose: Host side driving write words and the load strobe
// Assumes: A word is taken on the edge where wrValid is high
// Notes: Released data shows its inverse so stale values never match
module dac_host_model (
    input wire logic mclk,                  // Bench clock
    output logic wrValid,                   // Write pulse
    output dac_ctrl_pkg::regsel_t wrRegSel, // Register select
    output dac_ctrl_pkg::chan_t wrAddr,     // Channel address
    output dac_ctrl_pkg::code_t wrData,     // Data word
    output logic wrSelB,                    // B register target
    output logic burstMode,                 // Burst active
    output logic loadStrobeN                // Load strobe, low
);
    timeunit 1ns;
    timeprecision 1ps;
    import dac_ctrl_pkg::*;
    initial begin
        wrValid = 1'b0;
        wrRegSel = 2'h0;
        wrAddr = 6'h0;
        wrData = 14'h0;
        wrSelB = 1'b0;
        burstMode = 1'b0;
        loadStrobeN = 1'b1;
    end
    task automatic wr(input regsel_t rs, input chan_t ad, input code_t d,
                      input logic sb, input logic bm);
        @(posedge mclk);
        wrValid <= 1'b1;
        wrRegSel <= rs;
        wrAddr <= ad;
        wrData <= d;
        wrSelB <= sb;
        burstMode <= bm;
        @(posedge mclk);
        wrValid <= 1'b0;
        wrData <= ~d;
        wrAddr <= ~ad;
        burstMode <= 1'b0;
    endtask
    // Low long enough to pass the synchroniser, then wait out the scan
    task automatic strobe();
        @(posedge mclk);
        loadStrobeN <= 1'b0;
        repeat (4) @(posedge mclk);
        loadStrobeN <= 1'b1;
        repeat (46) @(posedge mclk);
    endtask
endmodule

// ===== testbench/dac_toggle_monitor_ctrl_tb.sv
// Purpose: Self-checking bench for toggle, monitor and thermal control
// Assumes: Host model drives the write port and the load strobe
// Notes: Integer arrays mirror the A and B banks and group phases
`include "dac_ctrl_params.svh"
module dac_toggle_monitor_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dac_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic softPowerUp = 1'b0;
    logic overTemp = 1'b0;
    logic wrValid, wrSelB, burstMode, loadStrobeN;
    logic ampOn, lastMon, monOe, valid;
    regsel_t wrRegSel;
    chan_t wrAddr, monSel;
    code_t wrData, ctrl;
    logic [`NUM_CH*`CODE_W-1:0] dacCode;
    int bad_count = 0;
    int comparisons = 0;
    int modA[40], modB[40], phase[5], ctl;
    logic [31:0] seed = 32'h749b8f8c;
    logic [31:0] r;
    always #2 mclk = ~mclk;
    dac_host_model u_host (.mclk(mclk), .wrValid(wrValid),
        .wrRegSel(wrRegSel), .wrAddr(wrAddr), .wrData(wrData),
        .wrSelB(wrSelB), .burstMode(burstMode), .loadStrobeN(loadStrobeN));
    dac_toggle_monitor_ctrl u_dut (.mclk(mclk), .nrst(nrst),
        .wrValid(wrValid), .wrRegSel(wrRegSel), .wrAddr(wrAddr),
        .wrData(wrData), .wrSelB(wrSelB), .burstMode(burstMode),
        .softPowerUp(softPowerUp), .loadStrobeN(loadStrobeN),
        .overTemp(overTemp), .dacCode_q(dacCode), .ampOn_q(ampOn),
        .lastChIsMonitor_q(lastMon), .monitorSel_q(monSel),
        .monitorOe_q(monOe), .ctrlReg_q(ctrl), .outputsValid_q(valid));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input code_t e, input code_t g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic doReset(input int c);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (c) @(posedge mclk);
        nrst <= 1'b1;
        ctl = 0;
        foreach (modA[i]) modA[i] = 0;
        foreach (modB[i]) modB[i] = 0;
        foreach (phase[g]) phase[g] = 0;
        @(negedge mclk);
        for (int i = 0; i < 40; i++)
            chk("code", 14'h0, dacCode[14*i +: 14]);
        chk("ctrl", 14'h0, ctrl);
        chk("ampOn", 14'h1, code_t'(ampOn));
        chk("monOe", 14'h0, code_t'(monOe));
        chk("valid", 14'h0, code_t'(valid));
        $display("reset test done");
    endtask
    task automatic ctlWr(input int v);
        u_host.wr(2'h0, `CTRL_ADDR, code_t'(v), 1'b0, 1'b0);
        ctl = v;
        for (int g = 0; g < 5; g++)
            if (!ctl[2+g]) phase[g] = 0;
        @(negedge mclk);
        chk("ctrl", code_t'(v), ctrl);
    endtask
    task automatic dataWr(input int n, input logic sb, input logic bm);
        r = rnd();
        u_host.wr(2'h3, chan_t'(n), r[13:0], sb, bm);
        if (!sb)
            modA[n] = r[13:0];
        else if (ctl[2+n/8] && !bm)
            modB[n] = r[13:0];
    endtask
    task automatic strobeChk();
        u_host.strobe();
        for (int i = 0; i < 40; i++)
            chk("code", code_t'((ctl[2+i/8] && phase[i/8]) ? modB[i]
                : modA[i]), dacCode[14*i +: 14]);
        for (int g = 0; g < 5; g++)
            if (ctl[2+g]) phase[g] ^= 1;
        $display("strobe test done");
    endtask
    task automatic monWr(input int s, input logic oe, input int e);
        u_host.wr(2'h0, `MONSEL_ADDR, code_t'(s), 1'b0, 1'b0);
        @(negedge mclk);
        chk("monSel", code_t'(e), code_t'(monSel));
        chk("monOe", code_t'(oe), code_t'(monOe));
    endtask
    task automatic waitAmp(input logic e);
        for (int i = 0; i < 10 && ampOn !== e; i++) @(posedge mclk);
        chk("ampOn", code_t'(e), code_t'(ampOn));
        if (ampOn !== e) conclude();
    endtask
    task automatic pulseUp();
        @(posedge mclk);
        softPowerUp <= 1'b1;
        @(posedge mclk);
        softPowerUp <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic hot(input logic v);
        @(posedge mclk);
        overTemp <= v;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        doReset(10);
        for (int t = 0; t < 2; t++) begin
            r = rnd();
            ctlWr(t == 0 ? 32'h7c : int'(r & 32'h7c));
            for (int n = 0; n < 40; n++) dataWr(n, 1'b0, 1'b0);
            for (int n = 0; n < 40; n++) dataWr(n, 1'b1, 1'b0);
            dataWr(0, 1'b1, 1'b1);
            @(negedge mclk);
            chk("valid", 14'h1, code_t'(valid));
            repeat (3) strobeChk();
        end
        ctlWr(0);
        strobeChk();
        monWr(5, 1'b0, 63);
        ctlWr(32'h400);
        chk("lastMon", 14'h1, code_t'(lastMon));
        r = rnd();
        monWr(int'(r % 40), 1'b1, int'(r % 40));
        monWr(63, 1'b0, 63);
        $display("monitor test done");
        hot(1'b1);
        repeat (10) @(posedge mclk);
        chk("ampOn", 14'h1, code_t'(ampOn));
        ctlWr(32'h500);
        waitAmp(1'b0);
        pulseUp();
        chk("ampOn", 14'h0, code_t'(ampOn));
        hot(1'b0);
        repeat (4) @(posedge mclk);
        pulseUp();
        waitAmp(1'b1);
        hot(1'b1);
        waitAmp(1'b0);
        ctlWr(32'h400);
        waitAmp(1'b1);
        hot(1'b0);
        $display("thermal test done");
        doReset(2);
        conclude();
    end
endmodule
